// file: dv/alert_filter_nvm_control_checker.sv
// Port assertions for the alert, filter and NVM control block.
// Assumes one clock clk and async active-high reset rst.
`timescale 1ns/100ps
module alert_nvm_checker #(
  parameter int LOAD_CYCLES = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [alert_nvm_pkg::REG_W-1:0] reg_rdata,
  input wire logic bus_ready,
  input wire logic gc_valid,
  input wire logic ara_won,
  input wire logic meas_valid,
  input wire logic result_valid,
  input wire logic [13:0] result_tobj,
  input wire logic [15:0] corrected_sensor_voltage,
  input wire logic [13:0] tobj_final,
  input wire logic conv_abort,
  input wire logic alert_o,
  input wire logic alert_oe
);
  import alert_nvm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  logic cause;
  logic quiet;
  assign busy_cnt_nxt = bus_ready ? 32'h0 : busy_cnt_r + 32'h1;
  assign cause = result_valid | ara_won | reg_rd | reg_wr | conv_abort;
  assign quiet = !reg_wr && !gc_valid && bus_ready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  chk_pin_low: assert property (alert_oe |-> !alert_o)
    else $error("alert pin not driven low");
  chk_abort_ready: assert property (conv_abort == !bus_ready)
    else $error("conv_abort disagrees with bus_ready");
  chk_load_length: assert property ($rose(bus_ready) |->
    busy_cnt_r >= 32'(LOAD_CYCLES - 1) && busy_cnt_r <= 32'(LOAD_CYCLES + 2))
    else $error("load busy time wrong");
  chk_load_bound: assert property (busy_cnt_r <= 32'(LOAD_CYCLES + 2))
    else $error("load runs too long");
  chk_rdata_hold: assert property (!(reg_rd && bus_ready) |=>
    $stable(reg_rdata)) else $error("read data moved without read");
  chk_alert_rise: assert property ($rose(alert_oe) |->
    $past(result_valid) || $past(result_valid, 2) || $past(reg_wr)
    || $past(reg_wr, 2)) else $error("alert rose without cause");
  chk_alert_fall: assert property ($fell(alert_oe) |->
    $past(cause) || $past(cause, 2)) else $error("alert fell without cause");
  chk_filter_fixed: assert property (result_valid &&
    result_tobj == tobj_final |=> tobj_final == $past(result_tobj))
    else $error("filter moved off a steady input");
  chk_final_stable: assert property (!result_valid && quiet |=>
    $stable(tobj_final)) else $error("object result moved between results");
  chk_volt_stable: assert property (!meas_valid && quiet |=>
    $stable(corrected_sensor_voltage)) else $error("voltage moved idle");

  cov_load_done: cover property ($rose(bus_ready));
  cov_alert_on: cover property ($rose(alert_oe));
  cov_ara_alert: cover property (ara_won && alert_oe);
endmodule

bind alert_filter_nvm_control alert_nvm_checker #(
  .LOAD_CYCLES(LOAD_CYCLES)
) alert_nvm_checker_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ready(bus_ready),
  .gc_valid(gc_valid), .ara_won(ara_won), .meas_valid(meas_valid),
  .result_valid(result_valid), .result_tobj(result_tobj),
  .corrected_sensor_voltage(corrected_sensor_voltage),
  .tobj_final(tobj_final), .conv_abort(conv_abort), .alert_o(alert_o),
  .alert_oe(alert_oe));

// file: dv/alert_filter_nvm_control_test.sv
// Self-checking bench for the alert, filter and NVM control block.
// Assumes host_model on the register bus; LOAD_CYCLES shortened to 64.
`timescale 1ns/100ps
module alert_filter_nvm_control_test;
  import alert_nvm_pkg::*;
  typedef struct {logic [1:0] kind; logic [15:0] exp;
    logic [15:0] mask;} note_t;
  logic clk, rst, reg_wr, reg_rd, gc_valid, ara_won, meas_valid, chk_go;
  logic result_valid, result_not_valid, result_ovf, bus_ready;
  logic conv_abort, alert_oe;
  logic [7:0] reg_ptr, gc_byte;
  logic [15:0] reg_wdata, reg_rdata, meas_voltage, corrected_sensor_voltage;
  logic [13:0] meas_die, result_tobj, tobj_final, d;
  logic [15:0] v, w, s;
  logic [2:0] c;
  note_t n;
  note_t notes[$];
  int mismatches, compares, cyc, fin;

  host_model host_model_inst (.clk(clk), .bus_ready(bus_ready),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  alert_filter_nvm_control #(.LOAD_CYCLES(64)) alert_filter_nvm_control_inst (
    .clk(clk), .rst(rst), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_ready(bus_ready),
    .gc_valid(gc_valid), .gc_byte(gc_byte), .ara_won(ara_won),
    .meas_valid(meas_valid), .meas_voltage(meas_voltage), .meas_die(meas_die),
    .result_valid(result_valid), .result_tobj(result_tobj),
    .result_not_valid(result_not_valid), .result_ovf(result_ovf),
    .corrected_sensor_voltage(corrected_sensor_voltage),
    .tobj_final(tobj_final), .conv_abort(conv_abort), .alert_o(),
    .alert_oe(alert_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task note(input logic [1:0] k, input logic [15:0] e, input logic [15:0] m);
    notes.push_back('{k, e, m});
    @(negedge clk);
    chk_go = 1'b1;
    @(negedge clk);
    chk_go = 1'b0;
  endtask

  task wr(input logic [7:0] p, input logic [15:0] x);
    host_model_inst.xfer(1'b1, p, x);
  endtask

  task rdc(input logic [7:0] p, input logic [15:0] e, input logic [15:0] m);
    host_model_inst.xfer(1'b0, p, 16'h0000);
    note(2'd0, e, m);
  endtask

  task result(input logic [13:0] r);
    @(negedge clk);
    result_tobj = r;
    result_valid = 1'b1;
    @(negedge clk);
    result_valid = 1'b0;
    result_tobj = ~r;
    // Filter reference: (new + 4 * old) / 5, truncating toward zero
    fin = (int'($signed(r)) + 4 * fin) / 5;
    note(2'd1, 16'(fin), 16'h3fff);
  endtask

  task meas(input logic [15:0] x, input logic [13:0] y, input logic [15:0] e);
    @(negedge clk);
    meas_voltage = x;
    meas_die = y;
    meas_valid = 1'b1;
    @(negedge clk);
    meas_valid = 1'b0;
    note(2'd2, e, 16'hffff);
  endtask

  task pulse(input logic ara, input logic [7:0] b);
    @(negedge clk);
    ara_won = ara;
    gc_valid = !ara;
    gc_byte = b;
    @(negedge clk);
    ara_won = 1'b0;
    gc_valid = 1'b0;
  endtask

  task alert_is(input logic e);
    repeat (2) @(negedge clk);
    note(2'd3, {15'h0000, e}, 16'h0001);
  endtask

  always @(posedge clk) begin
    if (chk_go) begin
      n = notes.pop_front();
      case (n.kind)
        2'd0: s = reg_rdata;
        2'd1: s = {2'b00, tobj_final};
        2'd2: s = corrected_sensor_voltage;
        default: s = {15'h0000, alert_oe};
      endcase
      check(s & n.mask, n.exp & n.mask);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    {rst, chk_go, gc_valid, ara_won, meas_valid, result_valid} = 6'h20;
    {result_not_valid, result_ovf, gc_byte, meas_voltage} = 26'h0;
    {meas_die, result_tobj} = 28'h0;
    {mismatches, compares, cyc, fin} = '0;
    void'($urandom(29));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rdc(ADDR_CONFIG, 16'h1440, 16'hffff);
    rdc(ADDR_OBJ_HI, 16'h7fc0, 16'hffff);
    rdc(ADDR_NVM_ACC, 16'h0e00, 16'hffff);
    rdc(8'h1a, 16'h0000, 16'hffff);
    $display("test reset values done");
    v = 16'($urandom_range(0, 16'h3fff));
    d = 14'($urandom_range(0, 14'h0fff));
    meas(v, d, v);
    v = 16'($urandom_range(0, 16'h3fff));
    meas(v, d + 14'h10, v + 16'h0003);
    wr(ADDR_DIE_W, 16'h0000);
    v = 16'($urandom_range(0, 16'h3fff));
    meas(v, d + 14'h38, v);
    $display("test correction done");
    wr(ADDR_CONFIG, 16'h1540);
    wr(ADDR_MASK, 16'h2000);
    wr(ADDR_OBJ_HI, 16'h0040);
    result(14'h0300);
    alert_is(1'b1);
    pulse(1'b1, 8'h00);
    alert_is(1'b0);
    rdc(ADDR_STATUS, 16'h2000, 16'h2000);
    rdc(ADDR_STATUS, 16'h0000, 16'hffff);
    result(14'h0300);
    rdc(ADDR_STATUS, 16'ha000, 16'hb000);
    alert_is(1'b0);
    $display("test latched done");
    wr(ADDR_CONFIG, 16'h1560);
    wr(ADDR_MASK, 16'h3000);
    wr(ADDR_OBJ_LO, 16'hffc0);
    result(14'h0300);
    rdc(ADDR_STATUS, 16'h2000, 16'h3000);
    pulse(1'b1, 8'h00);
    alert_is(1'b1);
    rdc(ADDR_STATUS, 16'h2000, 16'h3000);
    result(14'h2000);
    rdc(ADDR_STATUS, 16'h0000, 16'h3000);
    alert_is(1'b0);
    // A steady input must leave the filtered result where it is
    result(14'(fin));
    $display("test comparator done");
    v = 16'($urandom) & 16'hffc0;
    wr(ADDR_OBJ_HI, v);
    wr(ADDR_NVM_ACC, 16'h5b32);
    rdc(ADDR_NVM_ACC, 16'h0e00, 16'hffff);
    for (int k = 1; k <= 9; k++) begin
      if (k == 9) wr(ADDR_OBJ_HI, v ^ 16'h8000);
      wr(ADDR_NVM_ACC, 16'h6a32);
      c = (k < 2) ? 3'h0 : (k > 8) ? 3'h7 : 3'(k - 1);
      rdc(ADDR_NVM_ACC, {c, 13'h0e30}, 16'hffff);
    end
    wr(ADDR_OBJ_HI, 16'h0000);
    wr(ADDR_NVM_ACC, 16'h6a31);
    rdc(ADDR_OBJ_HI, v, 16'hffff);
    wr(ADDR_OBJ_HI, 16'h1240);
    rdc(ADDR_OBJ_HI, 16'h1240, 16'hffff);
    $display("test store and load done");
    w = 16'($urandom) & 16'hffc0;
    wr(ADDR_OBJ_LO, w);
    wr(ADDR_NVM_ACC, 16'h6a04);
    rdc(ADDR_OBJ_HI, v, 16'hffff);
    rdc(ADDR_OBJ_LO, 16'h8000, 16'hffff);
    wr(ADDR_CONFIG, 16'h9400);
    rdc(ADDR_CONFIG, 16'h1440, 16'hffff);
    wr(ADDR_OBJ_LO, w);
    pulse(1'b0, 8'h04);
    rdc(ADDR_OBJ_LO, w, 16'hffff);
    pulse(1'b0, GC_RESET_CODE);
    rdc(ADDR_OBJ_LO, 16'h8000, 16'hffff);
    $display("test loads done");
    close_out();
  end
endmodule

// file: dv/host_model.sv
// Host side of the register bus: one-word strobed reads and writes.
// Assumes requests are gated by bus_ready; pins move at falling edges.
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic bus_ready,
  output logic [7:0] reg_ptr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_ptr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [7:0] p,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    // never ask while a load runs, unless it is still running after 4000 cycles
    while (!bus_ready && n < 4000) begin
      @(negedge clk);
      n++;
    end
    reg_ptr = p;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Released lines invert so a stale value never passes for fresh
    reg_ptr = ~p;
    reg_wdata = ~d;
  endtask
endmodule

// file: verilog/alert_filter_nvm_control.sv
// Transient correction, output filter, limit alerts and NVM load/store.
// Assumes a serial front end on clk that decodes register accesses and
// general calls; measurement strobes come from logic on the same clock.
`timescale 1ns/100ps
module alert_filter_nvm_control #(
  parameter int LOAD_CYCLES = alert_nvm_pkg::LOAD_CYCLES,
  // Identification values are arbitrary
  parameter logic [15:0] MFR_ID = 16'h5a5a,
  parameter logic [15:0] DEV_ID = 16'h0042
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [alert_nvm_pkg::REG_W-1:0] reg_wdata,
  output logic [alert_nvm_pkg::REG_W-1:0] reg_rdata,
  output logic bus_ready,
  input wire logic gc_valid,
  input wire logic [7:0] gc_byte,
  input wire logic ara_won,
  input wire logic meas_valid,
  input wire logic [15:0] meas_voltage,
  input wire logic [13:0] meas_die,
  input wire logic result_valid,
  input wire logic [13:0] result_tobj,
  input wire logic result_not_valid,
  input wire logic result_ovf,
  output logic [15:0] corrected_sensor_voltage,
  output logic [13:0] tobj_final,
  output logic conv_abort,
  output logic alert_o,
  output logic alert_oe
);
  import alert_nvm_pkg::*;

  nvm_if nv ();
  nvm_store u_store (
    .clk(clk),
    .rst(rst),
    .nv(nv)
  );

  logic [REG_W-1:0] regs_r [NUM_LOC];
  logic [REG_W-1:0] cfg, mask;
  logic load_busy, bus_wr, bus_rd, stat_rd;
  logic ld_wr_r;
  logic [IDX_W-1:0] ld_widx_r;
  logic [REG_W-1:0] ld_val;

  assign cfg = regs_r[ADDR_CONFIG[IDX_W-1:0]];
  assign mask = regs_r[ADDR_MASK[IDX_W-1:0]];
  assign bus_wr = reg_wr && !load_busy;
  assign bus_rd = reg_rd && !load_busy;
  assign stat_rd = bus_rd && reg_ptr == ADDR_STATUS;
  assign ld_val = nv.rd_stored ? nv.rd_data : por_value(ld_widx_r);

  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_reg
      if (WRITABLE_MASK[g]) begin : g_rw
        logic hit, ld_hit;
        logic [REG_W-1:0] wval;
        assign hit = bus_wr && reg_ptr == 8'(g);
        assign ld_hit = ld_wr_r && ld_widx_r == IDX_W'(g);
        // Soft reset bit self-clears so it never reads back set
        assign wval = (g == ADDR_CONFIG) ?
          (reg_wdata & ~(16'h0001 << CFG_RST_BIT)) : reg_wdata;
        always_ff @(posedge clk or posedge rst) begin
          if (rst) begin
            regs_r[g] <= por_value(IDX_W'(g));
          end else if (ld_hit) begin
            regs_r[g] <= ld_val;
          end else if (hit) begin
            regs_r[g] <= wval;
          end
        end
      end else begin : g_ro
        assign regs_r[g] = 16'h0000;
      end
    end
  endgenerate

  // Memory access decode
  logic acc_wr, key_ok, cmd_store, cmd_gen, cmd_single, cmd_swrst, cmd_gc;
  logic [IDX_W-1:0] tgt_idx;
  logic [IDX_W-1:0] acc_idx_r;
  assign acc_wr = bus_wr && reg_ptr == ADDR_NVM_ACC;
  // key must be in the same write
  assign key_ok = acc_wr && reg_wdata[NVM_KEY_LSB +: 8] == NVM_KEY;
  assign tgt_idx = reg_wdata[NVM_IDX_LSB +: IDX_W];
  assign cmd_store = key_ok && reg_wdata[NVM_STORE_BIT] &&
    WRITABLE_MASK[tgt_idx];
  assign cmd_gen = key_ok && reg_wdata[NVM_GEN_BIT];
  assign cmd_single = key_ok && reg_wdata[NVM_SINGLE_BIT];
  assign cmd_swrst = bus_wr && reg_ptr == ADDR_CONFIG &&
    reg_wdata[CFG_RST_BIT];
  assign cmd_gc = gc_valid && gc_byte == GC_RESET_CODE && !load_busy;

  assign nv.wr_en = cmd_store;
  assign nv.wr_idx = tgt_idx;
  assign nv.wr_data = regs_r[tgt_idx];
  assign nv.cnt_idx = acc_idx_r;

  // Load sequencer
  load_state_t ld_state_r, ld_state_nxt;
  logic pwr_pend_r, ld_all_r, ld_all_nxt, ld_start, ld_start_all;
  logic [IDX_W-1:0] ld_idx_r, ld_idx_nxt;
  logic [TIMER_W-1:0] ld_timer_r, ld_timer_nxt;
  logic ld_rd;

  assign ld_start_all = pwr_pend_r || cmd_swrst || cmd_gc || cmd_gen;
  assign ld_start = ld_start_all || cmd_single;
  assign ld_rd = ld_state_r == LD_WALK;
  assign nv.rd_idx = ld_idx_r;

  always_comb begin
    ld_state_nxt = ld_state_r;
    ld_idx_nxt = ld_idx_r;
    ld_all_nxt = ld_all_r;
    ld_timer_nxt = ld_timer_r + TIMER_W'(1);
    unique case (ld_state_r)
      LD_IDLE: begin
        ld_timer_nxt = '0;
        if (ld_start) begin
          ld_state_nxt = LD_WALK;
          ld_all_nxt = ld_start_all;
          ld_idx_nxt = ld_start_all ? '0 : tgt_idx;
        end
      end
      // walk all locations in one load, or only the target location for a single load
      LD_WALK: begin
        if (!ld_all_r || ld_idx_r == IDX_W'(NUM_LOC - 1)) begin
          ld_state_nxt = LD_HOLD;
        end else begin
          ld_idx_nxt = ld_idx_r + IDX_W'(1);
        end
      end
      // stay busy for the full load time
      LD_HOLD: begin
        if (ld_timer_r >= TIMER_W'(LOAD_CYCLES - 1)) begin
          ld_state_nxt = LD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_state_r <= LD_IDLE;
      pwr_pend_r <= 1'b1;
      ld_all_r <= 1'b0;
      ld_idx_r <= '0;
      ld_timer_r <= '0;
      ld_wr_r <= 1'b0;
      ld_widx_r <= '0;
      acc_idx_r <= '0;
    end else begin
      ld_state_r <= ld_state_nxt;
      pwr_pend_r <= 1'b0;
      ld_all_r <= ld_all_nxt;
      ld_idx_r <= ld_idx_nxt;
      ld_timer_r <= ld_timer_nxt;
      ld_wr_r <= ld_rd;
      ld_widx_r <= ld_idx_r;
      if (key_ok) begin
        acc_idx_r <= tgt_idx;
      end
    end
  end

  assign load_busy = ld_state_r != LD_IDLE || pwr_pend_r;
  assign bus_ready = !load_busy;
  assign conv_abort = load_busy;

  // Transient correction
  logic corr_on, meas_ev, res_ev;
  logic signed [13:0] die_prev_r;
  logic signed [15:0] volt_prev_r;
  logic prev_ok_r;
  logic signed [14:0] die_slope;
  logic signed [16:0] volt_slope;
  logic signed [30:0] term_die;
  logic signed [32:0] term_volt;
  logic signed [34:0] corr_sum;
  assign corr_on = cfg[CFG_CORRECT_BIT];
  assign meas_ev = meas_valid && !load_busy;
  assign res_ev = result_valid && !load_busy;
  // First sample after reset has no slope
  assign die_slope = prev_ok_r ?
    15'(signed'(meas_die)) - 15'(die_prev_r) : 15'sh0;
  assign volt_slope = prev_ok_r ?
    17'(signed'(meas_voltage)) - 17'(volt_prev_r) : 17'sh0;
  assign term_die = signed'(regs_r[ADDR_DIE_W[IDX_W-1:0]]) * die_slope;
  assign term_volt = signed'(regs_r[ADDR_VOLT_W[IDX_W-1:0]]) * volt_slope;
  assign corr_sum = 35'(signed'(meas_voltage)) +
    35'(term_die >>> WEIGHT_FRAC) + 35'(term_volt >>> WEIGHT_FRAC);

  // Output filter: the divide is by a constant and folds into adders
  logic signed [16:0] filt_sum, filt_q;
  logic [13:0] tobj_new;
  assign filt_sum = 17'(signed'(result_tobj)) +
    (17'(signed'(tobj_final)) <<< FILT_OLD_SHIFT);
  assign filt_q = filt_sum / FILT_DIV;
  assign tobj_new = corr_on ? filt_q[13:0] : result_tobj;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      die_prev_r <= 14'sh0;
      volt_prev_r <= 16'sh0;
      prev_ok_r <= 1'b0;
      corrected_sensor_voltage <= 16'h0000;
      tobj_final <= 14'h0000;
    end else begin
      if (meas_ev) begin
        die_prev_r <= meas_die;
        volt_prev_r <= meas_voltage;
        prev_ok_r <= 1'b1;
        corrected_sensor_voltage <= corr_on ? corr_sum[15:0] : meas_voltage;
      end
      if (res_ev) begin
        tobj_final <= tobj_new;
      end
    end
  end

  // Limit flags: bit 3 obj high, 2 obj low, 1 die high, 0 die low
  logic comp_mode;
  logic [3:0] lim_hit, lim_en, flags_r, flags_nxt, latch_set;
  logic signed [13:0] obj_hi, obj_lo, die_hi, die_lo, obj_t, die_t;
  logic alert_r, alert_nxt, not_valid_r, ovf_r;
  assign comp_mode = cfg[CFG_MODE_BIT];
  assign lim_en = mask[ST_LIMIT_LSB +: 4];
  assign obj_hi = {regs_r[ADDR_OBJ_HI[IDX_W-1:0]][15:LIM_LSB], 4'h0};
  assign obj_lo = {regs_r[ADDR_OBJ_LO[IDX_W-1:0]][15:LIM_LSB], 4'h0};
  assign die_hi = {regs_r[ADDR_DIE_HI[IDX_W-1:0]][15:LIM_LSB], 4'h0};
  assign die_lo = {regs_r[ADDR_DIE_LO[IDX_W-1:0]][15:LIM_LSB], 4'h0};
  assign obj_t = tobj_new;
  assign die_t = die_prev_r;
  assign lim_hit = {obj_t > obj_hi, obj_t < obj_lo,
    die_t > die_hi, die_t < die_lo};
  assign latch_set = res_ev ? (lim_hit & lim_en) : 4'h0;

  always_comb begin
    if (comp_mode) begin
      flags_nxt = flags_r;
      // comparator flags 3 and 1 move only at conversion end; flags 2 and 0 stay clear
      if (res_ev) begin
        flags_nxt[3] = lim_en[3] &&
          (lim_hit[3] || (flags_r[3] && !lim_hit[2]));
        flags_nxt[1] = lim_en[1] &&
          (lim_hit[1] || (flags_r[1] && !lim_hit[0]));
      end
      flags_nxt[2] = 1'b0;
      flags_nxt[0] = 1'b0;
      alert_nxt = flags_nxt[3] || flags_nxt[1];
    end else begin
      // status read clears, a new set still wins
      flags_nxt = (flags_r & ~{4{stat_rd}}) | latch_set;
      alert_nxt = (alert_r && !stat_rd && !ara_won) || (latch_set != 4'h0);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_r <= 4'h0;
      alert_r <= 1'b0;
      not_valid_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      alert_r <= alert_nxt;
      if (res_ev) begin
        not_valid_r <= result_not_valid;
        ovf_r <= result_ovf;
      end
    end
  end

  // Open-drain alert, active low
  assign alert_o = 1'b0;
  assign alert_oe = alert_r && cfg[CFG_ALERT_EN_BIT];

  // Read mux
  logic [REG_W-1:0] status_v, cfg_v, acc_v, rd_mux, rdata_r;
  assign status_v = {alert_r, 1'b0, flags_r, not_valid_r, 1'b0, ovf_r, 7'h00};
  assign cfg_v = cfg | (REG_W'(alert_r) << CFG_ALERT_FLAG_BIT);
  // write code of the last addressed location
  assign acc_v = {nv.cnt_code, 1'b0, NVM_FIXED, 1'b0, acc_idx_r, 3'h0};
  always_comb begin
    unique case (reg_ptr)
      ADDR_VSENSE: rd_mux = corrected_sensor_voltage;
      ADDR_TDIE: rd_mux = {die_prev_r, 2'h0};
      ADDR_CONFIG: rd_mux = cfg_v;
      ADDR_TOBJ: rd_mux = {tobj_final, 1'b0, not_valid_r};
      ADDR_STATUS: rd_mux = status_v;
      ADDR_MFR: rd_mux = MFR_ID;
      ADDR_DEV: rd_mux = DEV_ID;
      ADDR_NVM_ACC: rd_mux = acc_v;
      default: rd_mux = (reg_ptr < 8'(NUM_LOC)) ?
        regs_r[reg_ptr[IDX_W-1:0]] : 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (bus_rd) begin
      rdata_r <= rd_mux;
    end
  end
  assign reg_rdata = rdata_r;

endmodule

// file: verilog/alert_nvm_pkg.sv
// Constants, register map and types shared by the alert/filter/NVM block.
// Assumes a 200 MHz core clock; nothing else about the surroundings.
package alert_nvm_pkg;

  localparam int REG_W = 16;
  localparam int IDX_W = 5;
  localparam int NUM_LOC = 32;

  // Register pointers
  localparam logic [7:0] ADDR_VSENSE = 8'h00;
  localparam logic [7:0] ADDR_TDIE = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_TOBJ = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h05;
  localparam logic [7:0] ADDR_OBJ_HI = 8'h06;
  localparam logic [7:0] ADDR_OBJ_LO = 8'h07;
  localparam logic [7:0] ADDR_DIE_HI = 8'h08;
  localparam logic [7:0] ADDR_DIE_LO = 8'h09;
  localparam logic [7:0] ADDR_DIE_W = 8'h11;
  localparam logic [7:0] ADDR_VOLT_W = 8'h12;
  localparam logic [7:0] ADDR_MFR = 8'h1e;
  localparam logic [7:0] ADDR_DEV = 8'h1f;
  localparam logic [7:0] ADDR_NVM_ACC = 8'h2a;

  // Locations 02h, 05h and 06h..12h are software writable
  localparam logic [NUM_LOC-1:0] WRITABLE_MASK = 32'h0007_ffe4;

  // Configuration fields
  localparam int CFG_RST_BIT = 15;
  localparam int CFG_ALERT_EN_BIT = 8;
  localparam int CFG_ALERT_FLAG_BIT = 7;
  localparam int CFG_CORRECT_BIT = 6;
  localparam int CFG_MODE_BIT = 5;

  // Status and mask fields; limit flags sit in bits 13:10
  localparam int ST_ALERT_BIT = 15;
  localparam int ST_LIMIT_LSB = 10;
  localparam int ST_NOT_VALID_BIT = 9;
  localparam int ST_MEMC_BIT = 8;
  localparam int ST_OVF_BIT = 7;
  localparam int LIM_LSB = 6;

  // Memory access register fields
  localparam logic [7:0] NVM_KEY = 8'h6a;
  localparam int NVM_KEY_LSB = 8;
  localparam int NVM_IDX_LSB = 3;
  localparam int NVM_GEN_BIT = 2;
  localparam int NVM_STORE_BIT = 1;
  localparam int NVM_SINGLE_BIT = 0;
  localparam logic [2:0] NVM_FIXED = 3'h7;
  localparam logic [3:0] NVM_MAX_WRITES = 4'h8;

  localparam logic [7:0] GC_RESET_CODE = 8'h06;

  // Load timing
  localparam int CLK_HZ = 200_000_000;
  localparam int LOAD_TIME_MS = 3;
  localparam int LOAD_CYCLES = LOAD_TIME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 20;

  // Filtering: final = (1 * new + 4 * old) / 5
  localparam int FILT_OLD_SHIFT = 2;
  localparam logic signed [16:0] FILT_DIV = 17'sh5;
  localparam int WEIGHT_FRAC = 8;

  typedef enum logic [1:0] {LD_IDLE, LD_WALK, LD_HOLD} load_state_t;

  function automatic logic [REG_W-1:0] por_value(input logic [IDX_W-1:0] i);
    logic [REG_W-1:0] v;
    v = 16'h0000;
    unique case (i)
      5'h02: v = 16'h1440;
      5'h06: v = 16'h7fc0;
      5'h07: v = 16'h8000;
      5'h08: v = 16'h7fc0;
      5'h09: v = 16'h8000;
      5'h0a: v = 16'h260e;
      5'h0b: v = 16'h0106;
      5'h0c: v = 16'hff9b;
      5'h0d: v = 16'hff3a;
      5'h0e: v = 16'hff71;
      5'h0f: v = 16'h0553;
      5'h11: v = 16'h0034;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

endpackage

// file: verilog/nvm_if.sv
// Carrier between the controller and the nonvolatile store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface nvm_if;
  import alert_nvm_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_data;
  logic rd_stored;
  logic [IDX_W-1:0] cnt_idx;
  logic [2:0] cnt_code;
  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, cnt_idx,
    input rd_data, rd_stored, cnt_code);
  modport store (input wr_en, wr_idx, wr_data, rd_idx, cnt_idx,
    output rd_data, rd_stored, cnt_code);
endinterface

// file: verilog/nvm_store.sv
// Nonvolatile location array with per-location write counters.
// Assumes a single clock; reads come out of registers one cycle later.
`timescale 1ns/100ps
module nvm_store (
  input wire logic clk,
  input wire logic rst,
  nvm_if.store nv
);
  import alert_nvm_pkg::*;

  logic [REG_W-1:0] data_r [NUM_LOC];
  logic [3:0] writes_r [NUM_LOC];
  logic [REG_W-1:0] rd_data_r;
  logic rd_stored_r;
  logic [2:0] cnt_code_r;
  logic [3:0] sel_writes;
  logic [3:0] rd_writes;

  assign sel_writes = writes_r[nv.cnt_idx];
  assign rd_writes = writes_r[nv.rd_idx];

  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_loc
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          writes_r[g] <= 4'h0;
        end else if (nv.wr_en && nv.wr_idx == IDX_W'(g) &&
                     writes_r[g] < NVM_MAX_WRITES) begin
          writes_r[g] <= writes_r[g] + 4'h1;
        end
      end
      always_ff @(posedge clk) begin
        if (nv.wr_en && nv.wr_idx == IDX_W'(g) &&
            writes_r[g] < NVM_MAX_WRITES) begin
          data_r[g] <= nv.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 16'h0000;
      rd_stored_r <= 1'b0;
      cnt_code_r <= 3'h0;
    end else begin
      rd_data_r <= data_r[nv.rd_idx];
      rd_stored_r <= rd_writes != 4'h0;
      // code 000 for zero or one
      cnt_code_r <= (sel_writes <= 4'h1) ? 3'h0 : 3'(sel_writes - 4'h1);
    end
  end

  assign nv.rd_data = rd_data_r;
  assign nv.rd_stored = rd_stored_r;
  assign nv.cnt_code = cnt_code_r;

endmodule
